// >>> ffcbs_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "ffcbs_regs.svh"
// Notes on behaviour
// - point count is taken only on the start beat and sets frame length
// - with variable length off, every frame uses the maximum length
// - output point count travels with each output frame
// - direction high on the start beat selects inverse transform
// - framing faults on the input stream show on the error output
// - code 01 when a frame begins without a start marker
// - code 10 when the Nth sample carries no end marker
// - code 11 when the end marker comes before N samples
// - input is plain fixed point with implicit exponent zero
// - each pass input is scaled from the previous pass block range
// - shifts of all passes sum into one block exponent
// - storage keeps three guard bits for per-pass growth
// - block shifts right when a pass produced carry-out bits
// - shift is measured growth of the largest sample versus width
// - largest growth is held in one register, restarted at the end of each load or pass
// - one shared engine reads, processes and writes back each pass
// - true magnitude is output times two to minus exponent
// - exponent is a six-bit signed output
// - error output is upstream error ORed with internal errors
// - a sample moves only when valid and ready are both high
module ffcbs_core (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // input stream
  input wire ffcbs_pkg::ffcbs_sink_t sink_i,
  output logic sink_ready_o,
  // output stream
  output ffcbs_pkg::ffcbs_source_t src_o,
  input wire logic src_ready_i,
  // register bus
  input wire ffcbs_pkg::ffcbs_avm_t avm_i,
  output logic [31:0] avm_readdata_o,
  output logic avm_waitrequest_o
);
  localparam int DW = `FFCBS_DATA_W;
  localparam int MW = `FFCBS_MEM_W;
  localparam int EW = `FFCBS_EXP_W;
  localparam int NP = int'(`FFCBS_MAX_PTS);

  // --------------------------------------------------------------
  // reset synchroniser
  // --------------------------------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;
  // release through two flops
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // bits needed for a signed value
  function automatic logic [4:0] bits_of(input logic signed [MW-1:0] x);
    logic [4:0] n;
    n = 5'h1;
    for (int b = 0; b < MW - 1; b++) begin
      if (x[b] != x[MW-1]) begin
        n = 5'(b + 2);
      end
    end
    return n;
  endfunction

  // signed shift, positive is right
  function automatic logic signed [MW-1:0] shift_by(input logic signed [MW-1:0] x,
                                                    input logic signed [EW-1:0] sh);
    logic [EW-1:0] mag;
    mag = sh[EW-1] ? EW'(-sh) : sh;
    return sh[EW-1] ? (x <<< mag) : (x >>> mag);
  endfunction

  function automatic logic [3:0] log2_of(input logic [8:0] n);
    logic [3:0] r;
    r = 4'h0;
    for (int b = 0; b < 9; b++) begin
      if (n[b]) begin
        r = 4'(b);
      end
    end
    return r;
  endfunction

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  ffcbs_pkg::ffcbs_state_t state;
  ffcbs_pkg::ffcbs_state_t next_state;
  logic [8:0] cnt;
  logic [3:0] pass_q;
  logic [3:0] log2_q;
  logic [8:0] npts_q;
  logic inv_q;
  logic [1:0] err_q;
  logic signed [EW-1:0] exp_q;
  logic signed [EW-1:0] shift_q;
  logic [4:0] meas_q;
  logic var_en;
  logic [31:0] frames_q;
  logic signed [MW-1:0] mem_re [NP];
  logic signed [MW-1:0] mem_im [NP];

  // --------------------------------------------------------------
  // input framing
  // --------------------------------------------------------------
  // transfer on valid and ready
  wire accept = ce_i & sink_i.valid & sink_ready_o;
  wire first = (cnt == 9'h0);
  wire in_load = (state == ffcbs_pkg::ST_LOAD);
  wire [8:0] in_npts = (var_en && sink_i.pts != '0) ? {1'b0, sink_i.pts} : `FFCBS_MAX_PTS;
  wire [8:0] npts = first ? in_npts : npts_q;
  wire [8:0] cnt_inc = cnt + 9'h1;
  wire sop_miss = accept & first & ~sink_i.sop;
  wire beat_ok = accept & ~sop_miss;
  wire early_eop = beat_ok & sink_i.eop & (cnt_inc < npts);
  wire load_done = beat_ok & (cnt_inc == npts);
  wire eop_miss = load_done & ~sink_i.eop;
  wire [1:0] err_new = err_q | (accept ? sink_i.error : `FFCBS_ERR_NONE) |
                       (sop_miss ? `FFCBS_ERR_SOP : `FFCBS_ERR_NONE) |
                       (early_eop ? `FFCBS_ERR_EARLY : `FFCBS_ERR_NONE) |
                       (eop_miss ? `FFCBS_ERR_EOP : `FFCBS_ERR_NONE);
  wire in_inv = first ? sink_i.inverse : inv_q;
  wire signed [MW-1:0] in_re = in_inv ? MW'(sink_i.im) : MW'(sink_i.re);
  wire signed [MW-1:0] in_im = in_inv ? MW'(sink_i.re) : MW'(sink_i.im);
  wire [4:0] in_b_re = bits_of(in_re);
  wire [4:0] in_b_im = bits_of(in_im);
  wire [4:0] in_bits = (in_b_re > in_b_im) ? in_b_re : in_b_im;

  // --------------------------------------------------------------
  // shared pass engine
  // --------------------------------------------------------------
  // pair addressing for one pass
  wire [3:0] hl = log2_q - pass_q - 4'h1;
  wire [7:0] half = 8'(9'h1 << hl);
  wire [7:0] mask = half - 8'h1;
  wire [7:0] idx_a = ((cnt[7:0] & ~mask) << 1) | (cnt[7:0] & mask);
  wire [7:0] idx_b = idx_a | half;
  wire signed [MW-1:0] a_re = shift_by(mem_re[idx_a], shift_q);
  wire signed [MW-1:0] a_im = shift_by(mem_im[idx_a], shift_q);
  wire signed [MW-1:0] b_re = shift_by(mem_re[idx_b], shift_q);
  wire signed [MW-1:0] b_im = shift_by(mem_im[idx_b], shift_q);
  wire signed [MW-1:0] sum_re = a_re + b_re;
  wire signed [MW-1:0] sum_im = a_im + b_im;
  wire signed [MW-1:0] dif_re = a_re - b_re;
  wire signed [MW-1:0] dif_im = a_im - b_im;
  wire [4:0] pb0 = bits_of(sum_re);
  wire [4:0] pb1 = bits_of(sum_im);
  wire [4:0] pb2 = bits_of(dif_re);
  wire [4:0] pb3 = bits_of(dif_im);
  wire [4:0] pb01 = (pb0 > pb1) ? pb0 : pb1;
  wire [4:0] pb23 = (pb2 > pb3) ? pb2 : pb3;
  wire [4:0] pass_bits = (pb01 > pb23) ? pb01 : pb23;
  wire in_pass = (state == ffcbs_pkg::ST_PASS);
  wire last_pair = (cnt == {1'b0, npts_q[8:1]} - 9'h1);
  wire last_pass = (pass_q == log2_q - 4'h1);

  // --------------------------------------------------------------
  // block range and exponent
  // --------------------------------------------------------------
  // running largest growth
  wire [4:0] cur_bits = in_pass ? pass_bits : in_bits;
  wire [4:0] meas_base = (in_load && first) ? 5'h1 : meas_q;
  wire [4:0] meas_new = (cur_bits > meas_base) ? cur_bits : meas_base;
  // positive means carry bits to drop
  wire signed [EW-1:0] shift_new = $signed({1'b0, meas_new}) - EW'(DW);
  wire signed [EW-1:0] exp_base = (in_load && first) ? '0 : exp_q;
  wire stage_end = (in_load & load_done) | (in_pass & ce_i & last_pair);

  // exponent is minus net right shift
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= '0;
      exp_q <= '0;
      meas_q <= 5'h1;
    end else if (stage_end) begin
      shift_q <= shift_new;
      exp_q <= exp_base - shift_new;
      meas_q <= 5'h1;
    end else if (beat_ok || (ce_i && in_pass)) begin
      meas_q <= meas_new;
      exp_q <= exp_base;
    end
  end

  // --------------------------------------------------------------
  // sequencing
  // --------------------------------------------------------------
  wire out_ready = ~src_o.valid | src_ready_i;
  wire out_last = (cnt_inc == npts_q);

  // next state
  always_comb begin
    next_state = state;
    unique case (state)
      ffcbs_pkg::ST_LOAD: if (load_done) begin
        next_state = (log2_of(npts) == 4'h0) ? ffcbs_pkg::ST_OUT : ffcbs_pkg::ST_PASS;
      end
      ffcbs_pkg::ST_PASS: if (ce_i && last_pair && last_pass) begin
        next_state = ffcbs_pkg::ST_OUT;
      end
      ffcbs_pkg::ST_OUT: if (ce_i && out_ready && out_last) begin
        next_state = ffcbs_pkg::ST_LOAD;
      end
    endcase
  end

  // state, ready and error flops
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ffcbs_pkg::ST_LOAD;
      sink_ready_o <= 1'b0;
      err_q <= `FFCBS_ERR_NONE;
    end else if (ce_i) begin
      state <= next_state;
      sink_ready_o <= (next_state == ffcbs_pkg::ST_LOAD);
      err_q <= err_new;
    end
  end

  // sample, pair and output index
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 9'h0;
      pass_q <= 4'h0;
      frames_q <= 32'h0;
    end else if (ce_i) begin
      unique case (state)
        ffcbs_pkg::ST_LOAD: begin
          pass_q <= 4'h0;
          if (early_eop || load_done) begin
            cnt <= 9'h0;
          end else if (beat_ok) begin
            cnt <= cnt_inc;
          end
        end
        ffcbs_pkg::ST_PASS: begin
          cnt <= last_pair ? 9'h0 : cnt_inc;
          pass_q <= last_pair ? pass_q + 4'h1 : pass_q;
        end
        ffcbs_pkg::ST_OUT: if (out_ready) begin
          cnt <= out_last ? 9'h0 : cnt_inc;
          frames_q <= out_last ? frames_q + 32'h1 : frames_q;
        end
      endcase
    end
  end

  // per-frame settings from the start beat
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      npts_q <= `FFCBS_MAX_PTS;
      log2_q <= 4'h0;
      inv_q <= 1'b0;
    end else if (beat_ok && first) begin
      npts_q <= in_npts;
      log2_q <= log2_of(in_npts);
      inv_q <= sink_i.inverse;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (ce_i && beat_ok) begin
      mem_re[cnt[7:0]] <= in_re;
      mem_im[cnt[7:0]] <= in_im;
    end else if (ce_i && in_pass) begin
      mem_re[idx_a] <= sum_re;
      mem_im[idx_a] <= sum_im;
      mem_re[idx_b] <= dif_re;
      mem_im[idx_b] <= dif_im;
    end
  end

  // --------------------------------------------------------------
  // output stream
  // --------------------------------------------------------------
  wire signed [MW-1:0] o_re = shift_by(mem_re[cnt[7:0]], shift_q);
  wire signed [MW-1:0] o_im = shift_by(mem_im[cnt[7:0]], shift_q);

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      src_o <= '0;
    end else if (ce_i) begin
      // every field, error too, holds while a beat is stalled
      if (out_ready) begin
        src_o.error <= err_new;
        src_o.valid <= (state == ffcbs_pkg::ST_OUT);
        src_o.sop <= first;
        src_o.eop <= out_last;
        src_o.exp <= exp_q;
        src_o.pts <= npts_q[7:0];
        src_o.re <= inv_q ? o_im[DW-1:0] : o_re[DW-1:0];
        src_o.im <= inv_q ? o_re[DW-1:0] : o_im[DW-1:0];
      end
    end
  end

  // --------------------------------------------------------------
  // register bus slave
  // --------------------------------------------------------------
  wire [3:0] adr = avm_i.address;
  wire wr_take = avm_i.write & ~avm_waitrequest_o;
  wire [31:0] stat_val = {18'h0, exp_q, 3'h0, state == ffcbs_pkg::ST_OUT, in_pass, in_load, err_q};
  wire [31:0] rd_val = (adr == `FFCBS_REG_CTRL) ? {31'h0, var_en} :
                       (adr == `FFCBS_REG_STAT) ? stat_val :
                       (adr == `FFCBS_REG_FRAMES) ? frames_q : 32'h0;

  // one wait cycle per access
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avm_waitrequest_o <= 1'b1;
      avm_readdata_o <= 32'h0;
      var_en <= `FFCBS_CTRL_VAR_RESET;
    end else if (ce_i) begin
      avm_waitrequest_o <= ~(avm_i.read | avm_i.write) | ~avm_waitrequest_o;
      if (avm_i.read && avm_waitrequest_o) begin
        avm_readdata_o <= rd_val;
      end
      if (wr_take && adr == `FFCBS_REG_CTRL && avm_i.byteenable[0]) begin
        var_en <= avm_i.writedata[`FFCBS_CTRL_VAR_BIT];
      end
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_pts_capture;
    beat_ok && first && var_en |=> npts_q == $past(in_npts);
  endproperty
  a_pts_capture: assert property (p_pts_capture) else $error("point count not captured");
  property p_fixed_len;
    beat_ok && first && !var_en |=> npts_q == `FFCBS_MAX_PTS;
  endproperty
  a_fixed_len: assert property (p_fixed_len) else $error("fixed length not used");
  property p_inverse;
    beat_ok && first |=> inv_q == $past(sink_i.inverse);
  endproperty
  a_inverse: assert property (p_inverse) else $error("direction not captured");
  property p_miss_sop;
    sop_miss |=> err_q[0] && cnt == 9'h0;
  endproperty
  a_miss_sop: assert property (p_miss_sop) else $error("missing start not flagged");
  property p_early_eop;
    early_eop |=> err_q == `FFCBS_ERR_EARLY && cnt == 9'h0 && in_load;
  endproperty
  a_early_eop: assert property (p_early_eop) else $error("early end not flagged");
  property p_miss_eop;
    eop_miss |=> err_q[1] && !in_load;
  endproperty
  a_miss_eop: assert property (p_miss_eop) else $error("missing end not flagged");
  property p_err_hold;
    err_q != `FFCBS_ERR_NONE |=> (err_q != `FFCBS_ERR_NONE)[*4];
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error code dropped");
  property p_err_or;
    accept && out_ready |=> (src_o.error & $past(sink_i.error)) == $past(sink_i.error);
  endproperty
  a_err_or: assert property (p_err_or) else $error("upstream error lost");
  property p_out_hold;
    src_o.valid && !src_ready_i |=> $stable(src_o);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("stalled output beat changed");
  property p_ready_load;
    sink_ready_o |-> in_load;
  endproperty
  a_ready_load: assert property (p_ready_load) else $error("ready outside load");
  property p_exp_step;
    stage_end |=> shift_q + exp_q == $past(exp_base);
  endproperty
  a_exp_step: assert property (p_exp_step) else $error("exponent step wrong");
  property p_out_frame;
    src_o.valid && src_o.sop |-> src_o.pts == npts_q[7:0] && src_o.exp == exp_q;
  endproperty
  a_out_frame: assert property (p_out_frame) else $error("frame tags misaligned");
  c_frame_out: cover property (src_o.valid && src_o.eop && src_ready_i);
  c_sop_err: cover property (sop_miss);
  c_early: cover property (early_eop);
  c_inverse: cover property (beat_ok && first && sink_i.inverse);
endmodule // ffcbs_core
`default_nettype wire

// >>> ffcbs_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ffcbs_regs.svh"
module ffcbs_core_tb;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic slow = 1'b0;
  ffcbs_pkg::ffcbs_sink_t sink;
  ffcbs_pkg::ffcbs_source_t src;
  ffcbs_pkg::ffcbs_avm_t avm = '0;
  logic sink_ready;
  logic src_ready;
  logic waitreq;
  logic [31:0] rdata;
  logic [31:0] q;
  int checks = 0;
  int bad_count = 0;
  int cycles = 0;

  // 200 mhz clock
  always #2.5 core_clk_i = ~core_clk_i;

  ffcbs_core DUT (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .sink_i(sink),
    .sink_ready_o(sink_ready), .src_o(src), .src_ready_i(src_ready), .avm_i(avm),
    .avm_readdata_o(rdata), .avm_waitrequest_o(waitreq));

  ffcbs_stream_partner partner (.core_clk_i(core_clk_i), .slow_i(slow), .sink_o(sink),
    .sink_ready_i(sink_ready), .src_i(src), .src_ready_o(src_ready));

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avm <= '{read: !wr, write: wr, address: a, byteenable: 4'hf, writedata: d};
    do @(posedge core_clk_i); while (waitreq !== 1'b0);
    q = rdata;
    avm <= '0;
    @(posedge core_clk_i);
  endtask

  // reset held 8 cycles, bus allowed from edge 3
  task automatic restart();
    reset_n_i <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    partner.rx_q.delete();
    reset_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
  endtask

  // queue one frame; count and direction differ on later beats
  task automatic send(input int n, input logic [7:0] pts, input int eop_at, input logic sop,
                      input logic inv, input logic [1:0] err, input logic [15:0] re);
    ffcbs_pkg::ffcbs_sink_t b;
    for (int i = 0; i < n; i++) begin
      b = '0;
      b.valid = 1'b1;
      b.sop = sop && i == 0;
      b.eop = i == eop_at;
      b.inverse = (i == 0) ? inv : !inv;
      b.pts = (i == 0) ? pts : ~pts;
      b.error = err;
      b.re = re;
      partner.tx_q.push_back(b);
    end
  endtask

  task automatic drain();
    while (partner.tx_q.size() > 0 || sink.valid) @(posedge core_clk_i);
    repeat (2) @(posedge core_clk_i);
  endtask

  // rescale by block exponent
  // output sample scaled back by the block exponent
  function automatic logic [31:0] true_mag(input ffcbs_pkg::ffcbs_source_t s);
    logic signed [31:0] m;
    m = s.re;
    return (s.exp < 0) ? m <<< -s.exp : m >>> s.exp;
  endfunction

  // wait for a frame, check framing, dc bin and the rest zero
  task automatic recv(input int n, input logic [7:0] pts, input logic [1:0] err, input logic [31:0] dc);
    while (partner.rx_q.size() < n) @(posedge core_clk_i);
    for (int i = 0; i < n; i++) begin
      check({partner.rx_q[i].sop, partner.rx_q[i].eop}, {i == 0, i == n - 1});
      check(partner.rx_q[i].pts, pts);
      check(partner.rx_q[i].exp, partner.rx_q[0].exp);
      check(partner.rx_q[i].error, err);
      check(true_mag(partner.rx_q[i]), (i == 0) ? dc : 32'h0);
      check(partner.rx_q[i].im, 32'h0);
    end
    repeat (n) void'(partner.rx_q.pop_front());
  endtask

  // ---------------------------------------------
  // watchdog
  // ---------------------------------------------
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  // ---------------------------------------------
  // test sequence
  // ---------------------------------------------
  initial begin
    restart();
    bus(1'b0, `FFCBS_REG_CTRL, 32'h0);
    check(q, 32'h1);
    bus(1'b0, `FFCBS_REG_STAT, 32'h0);
    check(q & 32'h1f, 32'h4);
    bus(1'b1, `FFCBS_REG_STAT, 32'hff);
    bus(1'b0, `FFCBS_REG_STAT, 32'h0);
    check(q & 32'h3, 32'h0);
    bus(1'b0, 4'hc, 32'h0);
    check(q, 32'h0);
    $display("test registers done");

    // inverse two point frame then forward four point frame, downstream stalling
    slow <= 1'b1;
    send(2, 8'h02, 1, 1'b1, 1'b1, 2'h0, 16'h4000);
    send(4, 8'h04, 3, 1'b1, 1'b0, 2'h1, 16'h2000);
    recv(2, 8'h02, 2'h0, 32'h8000);
    recv(4, 8'h04, 2'h1, 32'h8000);
    bus(1'b0, `FFCBS_REG_FRAMES, 32'h0);
    check(q, 32'h2);
    $display("test variable frames done");

    // upstream error reported, so reset before the next test
    restart();
    slow <= 1'b0;
    bus(1'b1, `FFCBS_REG_CTRL, 32'h0);
    bus(1'b0, `FFCBS_REG_CTRL, 32'h0);
    check(q, 32'h0);
    send(256, 8'h00, 255, 1'b1, 1'b0, 2'h0, 16'h0010);
    recv(256, 8'h00, 2'h0, 32'h1000);
    $display("test fixed length done");

    // framing faults: 1 no start, 2 no end, 3 early end
    for (int k = 1; k < 4; k++) begin
      restart();
      if (k == 1) send(2, 8'h02, 1, 1'b0, 1'b0, 2'h0, 16'h0100);
      if (k == 2) send(2, 8'h02, -1, 1'b1, 1'b0, 2'h0, 16'h0100);
      if (k == 3) send(2, 8'h04, 1, 1'b1, 1'b0, 2'h0, 16'h0100);
      drain();
      bus(1'b0, `FFCBS_REG_STAT, 32'h0);
      check(q[1:0], k[1:0]);
      check(src.error, k[1:0]);
      send(2, 8'h02, 1, 1'b1, 1'b0, 2'h0, 16'h0100);
      drain();
      bus(1'b0, `FFCBS_REG_STAT, 32'h0);
      check(q[1:0], k[1:0]);
    end
    $display("test framing faults done");
    end_of_test();
  end
endmodule // ffcbs_core_tb
`default_nettype wire

// >>> ffcbs_pkg.sv
`default_nettype none
`include "ffcbs_regs.svh"
package ffcbs_pkg;
  typedef enum logic [1:0] {ST_LOAD, ST_PASS, ST_OUT} ffcbs_state_t;

  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic inverse;
    logic [1:0] error;
    logic [`FFCBS_PTS_W-1:0] pts;
    logic signed [`FFCBS_DATA_W-1:0] re;
    logic signed [`FFCBS_DATA_W-1:0] im;
  } ffcbs_sink_t;

  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic [1:0] error;
    logic signed [`FFCBS_EXP_W-1:0] exp;
    logic [`FFCBS_PTS_W-1:0] pts;
    logic signed [`FFCBS_DATA_W-1:0] re;
    logic signed [`FFCBS_DATA_W-1:0] im;
  } ffcbs_source_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } ffcbs_avm_t;
endpackage
`default_nettype wire

// >>> ffcbs_regs.svh
`ifndef FFCBS_REGS_SVH
`define FFCBS_REGS_SVH
// sample and storage widths
`define FFCBS_DATA_W 16
`define FFCBS_GROW_W 3
`define FFCBS_MEM_W (`FFCBS_DATA_W + `FFCBS_GROW_W)
`define FFCBS_EXP_W 6
// point count field and maximum length
`define FFCBS_PTS_W 8
`define FFCBS_MAX_PTS 9'h100
// error codes
`define FFCBS_ERR_NONE 2'h0
`define FFCBS_ERR_SOP 2'h1
`define FFCBS_ERR_EOP 2'h2
`define FFCBS_ERR_EARLY 2'h3
// register byte offsets
`define FFCBS_REG_CTRL 4'h0
`define FFCBS_REG_STAT 4'h4
`define FFCBS_REG_FRAMES 4'h8
// control fields and reset values
`define FFCBS_CTRL_VAR_BIT 0
`define FFCBS_CTRL_VAR_RESET 1'h1
`endif

// >>> ffcbs_stream_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// upstream source and downstream sink model
// ---------------------------------------------
module ffcbs_stream_partner (
  // clock and stall control
  input wire logic core_clk_i,
  input wire logic slow_i,
  // toward the block input
  output ffcbs_pkg::ffcbs_sink_t sink_o,
  input wire logic sink_ready_i,
  // from the block output
  input wire ffcbs_pkg::ffcbs_source_t src_i,
  output logic src_ready_o
);
  ffcbs_pkg::ffcbs_sink_t tx_q[$];
  ffcbs_pkg::ffcbs_source_t rx_q[$];
  ffcbs_pkg::ffcbs_sink_t idle;
  logic [1:0] tick;

  // quiet lines at time zero
  initial begin
    sink_o = '0;
    src_ready_o = 1'b0;
    tick = 2'h0;
  end

  always @(posedge core_clk_i) begin
    if (!sink_o.valid || sink_ready_i) begin
      if (tx_q.size() > 0) begin
        sink_o <= tx_q.pop_front();
      end else begin
        idle = sink_o;
        idle.valid = 1'b0;
        idle.sop = 1'b0;
        idle.eop = 1'b0;
        idle.re = ~sink_o.re; // released data is not left stale
        idle.im = ~sink_o.im;
        sink_o <= idle;
      end
    end
  end

  // sink side capture
  // stalls two cycles of four when slow
  always @(posedge core_clk_i) begin
    tick <= tick + 2'h1;
    src_ready_o <= !slow_i || tick[1];
    if (src_i.valid && src_ready_o) begin
      rx_q.push_back(src_i);
    end
  end
endmodule // ffcbs_stream_partner
`default_nettype wire
